// [rtl/ssoc_pkg.sv]
// Shared constants, types and helpers for the sync / soft reset / one-shot control link
package ssoc_pkg;

  // Master clock
  localparam int CLK_NS = 10;

  // Serial frame layout: read flag, 7-bit address, 8-bit data
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] LAST_BIT = 5'(FRAME_BITS - 1);
  localparam logic [4:0] FRAME_RISES = 5'(FRAME_BITS);
  localparam int RW_BIT = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 8;
  localparam int DATA_MSB = 7;
  localparam logic RW_READ = 1'b1;

  // Data control register
  localparam logic [6:0] DC_ADDR = 7'h06;
  localparam logic [7:0] DC_RESET = 8'h80;
  localparam int SYNC_BIT = 7;
  localparam int ONESHOT_BIT = 4;
  localparam int SRST_MSB = 1;
  localparam int SRST_LSB = 0;
  localparam logic [1:0] SRST_STEP1 = 2'h3;
  localparam logic [1:0] SRST_STEP2 = 2'h2;
  localparam logic [15:0] POST_RESET_RESP = 16'h0E00;

  // Timing: each time in ns, each count derived from it
  localparam int SYNC_PULSE_NS = 40;
  localparam logic [3:0] SYNC_PULSE_CYC = 4'((SYNC_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam int SETTLE_NS = 20000;
  localparam logic [15:0] SETTLE_CYC = 16'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
  localparam int ODR_NS = 4000;
  localparam logic [15:0] ODR_LAST = 16'(ODR_NS / CLK_NS - 1);
  localparam int SCLK_HALF_NS = 80;
  localparam logic [3:0] HALF_LAST = 4'((SCLK_HALF_NS + CLK_NS - 1) / CLK_NS - 1);

  // Host controller Wishbone map (byte addresses)
  localparam logic [3:0] WB_CMD_OFS = 4'h0;
  localparam logic [3:0] WB_STAT_OFS = 4'h4;
  localparam logic [3:0] WB_RESP_OFS = 4'h8;
  localparam int ST_BUSY = 0;
  localparam int ST_RESP_NEW = 1;
  localparam int ST_READY = 2;
  localparam int ST_SYNC_LSB = 8;
  localparam int ST_SYNC_MSB = 15;

  // Host serial master states, Gray along the frame
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_LEAD = 2'b01,
    M_SHIFT = 2'b11,
    M_TRAIL = 2'b10
  } ssoc_mst_type;

  // Soft reset sequencer
  typedef enum logic {
    SR_IDLE = 1'b0,
    SR_ARMED = 1'b1
  } ssoc_srst_type;

  // Rising edge between two samples of a level
  function automatic logic ssoc_rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  // Read image of the data control register
  function automatic logic [7:0] ssoc_dc_pack(input logic sync, input logic oneshot,
                                              input logic [1:0] srst);
    logic [7:0] v;
    v = 8'h00;
    v[SYNC_BIT] = sync;
    v[ONESHOT_BIT] = oneshot;
    v[SRST_MSB:SRST_LSB] = srst;
    return v;
  endfunction

endpackage

// [rtl/ssoc_link_if.sv]
// Serial link and sync wiring between host controller and converter control logic
`timescale 1ns/100ps
interface ssoc_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic sync_out;
  logic sync_in;
  logic data_ready_pin;

  // Board wiring: sync output looped back to the sync input
  assign sync_in = sync_out;

  modport dev (
    input sclk,
    input cs_n,
    input mosi,
    output miso,
    output sync_out,
    input sync_in,
    output data_ready_pin
  );

  modport host (
    output sclk,
    output cs_n,
    output mosi,
    input miso,
    input sync_in,
    input data_ready_pin
  );
endinterface

// [rtl/ssoc_dev.sv]
// Converter-side data control logic: serial slave, sync, one-shot and soft reset
// Operation
// - data control at 0x06, resets to 0x80
// - software sync acts like start pulse
// - host writes sync bit low, then high
// - sync recognised at frame's last rising edge
// - sync driven out aligned to master clock
// - sync output wired back to sync input
// - every sync input pulse resets filters
// - no data until filters fully settled
// - daisy chain needs two sync pulses
// - shared clock, one ready pin: two pulses
// - bit 4 one-shot: one result per edge
// - soft reset needs 0x03 then 0x02
// - soft reset restores core and registers
// - after soft reset first answer 0x0E00
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/100ps
module ssoc_dev
  import ssoc_pkg::*;
(
  // Clock, reset, freeze
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic CE,
  // Link
  ssoc_link_if.dev LNK,
  // Core side
  output logic [7:0] DATA_CONTROL,
  output logic FILTER_RESET,
  output logic SETTLING,
  output logic CONV_STROBE,
  output logic CORE_RESET
);

  // Pin vector positions and idle levels (chip select idles high)
  localparam int P_SCLK = 0;
  localparam int P_CSN = 1;
  localparam int P_MOSI = 2;
  localparam int P_SYNC = 3;
  localparam logic [3:0] PIN_IDLE = 4'h2;

  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic [3:0] pin_d_r;
  wire [3:0] pins_in = {LNK.sync_in, LNK.mosi, LNK.cs_n, LNK.sclk};

  // Two-stage synchronisers, then one delay stage for edge finding
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_s1_r <= PIN_IDLE;
      pin_s2_r <= PIN_IDLE;
      pin_d_r <= PIN_IDLE;
    end else if (CE) begin
      pin_s1_r <= pins_in;
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end

  // Edge and level decode from the synchronised pins
  wire selected = ~pin_s2_r[P_CSN];
  wire sclk_rise = selected & ssoc_rise(pin_s2_r[P_SCLK], pin_d_r[P_SCLK]);
  wire sclk_fall = selected & ssoc_rise(pin_d_r[P_SCLK], pin_s2_r[P_SCLK]);
  wire cs_fall = ssoc_rise(pin_d_r[P_CSN], pin_s2_r[P_CSN]);
  wire sync_rise = ssoc_rise(pin_s2_r[P_SYNC], pin_d_r[P_SYNC]);
  wire mosi_bit = pin_s2_r[P_MOSI];

  logic [15:0] rx_r;
  logic [15:0] tx_r;
  logic [15:0] resp_r;
  logic [4:0] bit_cnt_r;

  // The word is complete at the sixteenth rising edge, not at chip select release
  wire frame_done = sclk_rise & (bit_cnt_r == LAST_BIT);
  wire [15:0] word = {rx_r[14:0], mosi_bit};
  wire cmd_read = (word[RW_BIT] == RW_READ);
  wire [6:0] cmd_addr = word[ADDR_MSB:ADDR_LSB];
  wire [7:0] cmd_data = word[DATA_MSB:0];
  wire dc_hit = (cmd_addr == DC_ADDR);
  wire dc_wr = frame_done & ~cmd_read & dc_hit;
  wire [1:0] srst_code = cmd_data[SRST_MSB:SRST_LSB];

  // Register state
  logic sync_bit_r;
  logic oneshot_r;
  logic [1:0] srst_field_r;
  ssoc_srst_type srst_state_r;
  logic post_reset_r;
  wire [7:0] dc_value = ssoc_dc_pack(sync_bit_r, oneshot_r, srst_field_r);

  // Second step only counts straight after an accepted first step
  wire soft_reset_go = dc_wr & (srst_state_r == SR_ARMED) & (srst_code == SRST_STEP2);
  // Low-to-high change of the sync bit, stored low and written high by this write, is the command
  wire sync_cmd = dc_wr & ~soft_reset_go & ~sync_bit_r & cmd_data[SYNC_BIT];

  // Serial shifter: receive on rising, present next bit on falling
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_r <= 16'h0000;
      tx_r <= 16'h0000;
      bit_cnt_r <= 5'h00;
    end else if (CE) begin
      if (cs_fall) begin
        bit_cnt_r <= 5'h00;
        tx_r <= resp_r;
      end else if (sclk_rise) begin
        rx_r <= word;
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end else if (sclk_fall) begin
        tx_r <= {tx_r[14:0], 1'b0};
      end
    end
  end

  assign LNK.miso = tx_r[15];

  // Answer for the next frame; first command after a soft reset gets the marker
  wire [15:0] resp_nxt = post_reset_r ? POST_RESET_RESP
                                      : {1'b0, cmd_addr, dc_hit ? dc_value : 8'h00};
  wire post_reset_nxt = soft_reset_go | (post_reset_r & ~frame_done);

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      resp_r <= 16'h0000;
      post_reset_r <= 1'b0;
    end else if (CE) begin
      if (frame_done) begin
        resp_r <= resp_nxt;
      end
      post_reset_r <= post_reset_nxt;
    end
  end

  // Data control register and soft reset sequencer.
  // Any write to the field that is neither a repeated first step nor the second step drops an armed first step,
  // so a stray write can never complete a reset later.
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sync_bit_r <= DC_RESET[SYNC_BIT];
      oneshot_r <= DC_RESET[ONESHOT_BIT];
      srst_field_r <= DC_RESET[SRST_MSB:SRST_LSB];
      srst_state_r <= SR_IDLE;
    end else if (CE) begin
      if (soft_reset_go) begin
        sync_bit_r <= DC_RESET[SYNC_BIT];
        oneshot_r <= DC_RESET[ONESHOT_BIT];
        srst_field_r <= DC_RESET[SRST_MSB:SRST_LSB];
        srst_state_r <= SR_IDLE;
      end else if (dc_wr) begin
        sync_bit_r <= cmd_data[SYNC_BIT];
        oneshot_r <= cmd_data[ONESHOT_BIT];
        srst_field_r <= srst_code;
        case (srst_state_r)
          SR_IDLE: begin
            srst_state_r <= (srst_code == SRST_STEP1) ? SR_ARMED : SR_IDLE;
          end
          SR_ARMED: begin
            srst_state_r <= (srst_code == SRST_STEP1) ? SR_ARMED : SR_IDLE;
          end
          default: begin
            srst_state_r <= SR_IDLE;
          end
        endcase
      end
    end
  end

  // Sync output pulse, counted on the master clock so every chained part sees it alike
  logic [3:0] sync_cnt_r;
  logic sync_out_r;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sync_cnt_r <= 4'h0;
      sync_out_r <= 1'b0;
    end else if (CE) begin
      if (soft_reset_go) begin
        sync_cnt_r <= 4'h0;
        sync_out_r <= 1'b0;
      end else if (sync_cmd) begin
        sync_cnt_r <= SYNC_PULSE_CYC;
        sync_out_r <= 1'b1;
      end else begin
        sync_out_r <= (sync_cnt_r > 4'h1);
        if (sync_cnt_r != 4'h0) begin
          sync_cnt_r <= sync_cnt_r - 4'h1;
        end
      end
    end
  end

  assign LNK.sync_out = sync_out_r;

  // Filter reset, settling and conversion timing.
  // Results are rate-based; one-shot only gates how many are released per sync edge.
  logic [15:0] settle_r;
  logic [15:0] odr_cnt_r;
  logic shot_armed_r;
  logic filt_rst_r;
  logic ready_r;
  wire odr_tick = (odr_cnt_r == ODR_LAST);
  wire settled = (settle_r == 16'h0000);
  wire conv_ok = odr_tick & settled & (~oneshot_r | shot_armed_r);

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      settle_r <= 16'h0000;
      odr_cnt_r <= 16'h0000;
      shot_armed_r <= 1'b0;
      filt_rst_r <= 1'b0;
      ready_r <= 1'b0;
    end else if (CE) begin
      filt_rst_r <= sync_rise & ~soft_reset_go;
      ready_r <= conv_ok & ~sync_rise & ~soft_reset_go;
      if (soft_reset_go) begin
        settle_r <= 16'h0000;
        odr_cnt_r <= 16'h0000;
        shot_armed_r <= 1'b0;
      end else if (sync_rise) begin
        settle_r <= SETTLE_CYC;
        odr_cnt_r <= 16'h0000;
        shot_armed_r <= 1'b1;
      end else begin
        odr_cnt_r <= odr_tick ? 16'h0000 : odr_cnt_r + 16'h0001;
        if (!settled) begin
          settle_r <= settle_r - 16'h0001;
        end
        if (conv_ok) begin
          shot_armed_r <= 1'b0;
        end
      end
    end
  end

  // Core side outputs
  logic core_rst_r;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      core_rst_r <= 1'b0;
    end else if (CE) begin
      core_rst_r <= soft_reset_go;
    end
  end

  assign LNK.data_ready_pin = ready_r;
  assign DATA_CONTROL = dc_value;
  assign FILTER_RESET = filt_rst_r;
  assign SETTLING = ~settled;
  assign CONV_STROBE = ready_r;
  assign CORE_RESET = core_rst_r;

endmodule

// [rtl/ssoc_host.sv]
// Host controller: Wishbone register slave driving the serial link as master
`timescale 1ns/100ps
module ssoc_host
  import ssoc_pkg::*;
(
  // Clock, reset, freeze
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic CE,
  // Wishbone classic slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Link
  ssoc_link_if.host LNK
);

  // Pin synchronisers: miso, sync loop, data ready
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;
  logic sync_d_r;
  wire [2:0] pins_in = {LNK.data_ready_pin, LNK.sync_in, LNK.miso};
  wire miso_bit = pin_s2_r[0];
  wire sync_rise = ssoc_rise(pin_s2_r[1], sync_d_r);

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
      sync_d_r <= 1'b0;
    end else if (CE) begin
      pin_s1_r <= pins_in;
      pin_s2_r <= pin_s1_r;
      sync_d_r <= pin_s2_r[1];
    end
  end

  // Bus decode; the access completes on the edge that sees ack high
  logic ack_r;
  logic [15:0] cmd_r;
  logic [15:0] resp_r;
  logic resp_new_r;
  logic [7:0] sync_seen_r;
  ssoc_mst_type state_r;
  wire busy = (state_r != M_IDLE);
  wire wb_req = WB_CYC_I & WB_STB_I & ~ack_r;
  wire wb_take = WB_CYC_I & WB_STB_I & ack_r;
  wire hit_cmd = (WB_ADR_I == WB_CMD_OFS);
  wire hit_stat = (WB_ADR_I == WB_STAT_OFS);
  wire hit_resp = (WB_ADR_I == WB_RESP_OFS);
  // One write, one frame: the two-write sequences stay in separate frames
  wire launch = wb_take & WB_WE_I & hit_cmd & ~busy;
  wire resp_read = wb_take & ~WB_WE_I & hit_resp;
  wire [15:0] cmd_nxt = {WB_SEL_I[1] ? WB_DAT_I[15:8] : cmd_r[15:8],
                         WB_SEL_I[0] ? WB_DAT_I[7:0] : cmd_r[7:0]};
  wire [31:0] stat_word = {16'h0000, sync_seen_r, 5'h00, pin_s2_r[2], resp_new_r, busy};
  wire [31:0] rd_mux = hit_cmd ? {16'h0000, cmd_r} :
                       hit_stat ? stat_word :
                       hit_resp ? {16'h0000, resp_r} : 32'h0000_0000;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ack_r <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
      cmd_r <= 16'h0000;
    end else if (CE) begin
      ack_r <= wb_req;
      if (wb_req) begin
        WB_DAT_O <= rd_mux;
      end
      if (launch) begin
        cmd_r <= cmd_nxt;
      end
    end
  end

  assign WB_ACK_O = ack_r;

  // Serial master: mode 0 frame, half period from the divider
  logic [3:0] div_r;
  logic [4:0] rises_r;
  logic [15:0] tx_r;
  logic [15:0] rx_r;
  logic sclk_r;
  logic cs_n_r;
  logic mosi_r;
  logic trail_cs_r;
  wire half_done = (div_r == HALF_LAST);
  wire frame_end = (state_r == M_TRAIL) & half_done & trail_cs_r;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_r <= M_IDLE;
      div_r <= 4'h0;
      rises_r <= 5'h00;
      tx_r <= 16'h0000;
      rx_r <= 16'h0000;
      sclk_r <= 1'b0;
      cs_n_r <= 1'b1;
      mosi_r <= 1'b0;
      trail_cs_r <= 1'b0;
    end else if (CE) begin
      div_r <= (half_done || state_r == M_IDLE) ? 4'h0 : div_r + 4'h1;
      case (state_r)
        M_IDLE: begin
          if (launch) begin
            cs_n_r <= 1'b0;
            tx_r <= cmd_nxt;
            mosi_r <= cmd_nxt[RW_BIT];
            rises_r <= 5'h00;
            state_r <= M_LEAD;
          end
        end
        M_LEAD: begin
          if (half_done) begin
            sclk_r <= 1'b1;
            rx_r <= {rx_r[14:0], miso_bit};
            rises_r <= 5'h01;
            state_r <= M_SHIFT;
          end
        end
        M_SHIFT: begin
          if (half_done && sclk_r) begin
            sclk_r <= 1'b0;
            if (rises_r == FRAME_RISES) begin
              trail_cs_r <= 1'b0;
              state_r <= M_TRAIL;
            end else begin
              tx_r <= {tx_r[14:0], 1'b0};
              mosi_r <= tx_r[14];
            end
          end else if (half_done) begin
            sclk_r <= 1'b1;
            rx_r <= {rx_r[14:0], miso_bit};
            rises_r <= rises_r + 5'h01;
          end
        end
        M_TRAIL: begin
          // Chip select stays high a full half period before the next frame
          if (half_done && !trail_cs_r) begin
            cs_n_r <= 1'b1;
            trail_cs_r <= 1'b1;
          end else if (half_done) begin
            state_r <= M_IDLE;
          end
        end
        default: begin
          state_r <= M_IDLE;
          cs_n_r <= 1'b1;
          sclk_r <= 1'b0;
        end
      endcase
    end
  end

  // Answer capture and sync pulse count; a new answer wins over its clear
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      resp_r <= 16'h0000;
      resp_new_r <= 1'b0;
      sync_seen_r <= 8'h00;
    end else if (CE) begin
      if (frame_end) begin
        resp_r <= rx_r;
      end
      resp_new_r <= frame_end | (resp_new_r & ~resp_read);
      if (sync_rise) begin
        sync_seen_r <= sync_seen_r + 8'h01;
      end
    end
  end

  assign LNK.sclk = sclk_r;
  assign LNK.cs_n = cs_n_r;
  assign LNK.mosi = mosi_r;

endmodule

// [tb/ssoc_asserts.sv]
// Link-side checker for the sync / soft reset / one-shot control pair
`timescale 1ns/100ps
module ssoc_asserts (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // Link wires
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic sync_out,
  input wire logic sync_in,
  input wire logic data_ready_pin
);
  logic sclk_q_r;
  logic sin_q_r;
  logic [4:0] rise_cnt_r;
  logic [4:0] rise_cnt_nxt;
  int rise_age_r;
  int rise_age_nxt;
  int sync_age_r;
  int sync_age_nxt;
  wire sclk_rise = sclk & ~sclk_q_r;
  wire sin_rise = sync_in & ~sin_q_r;

  // Ages saturate so they never wrap into a false pass
  assign rise_cnt_nxt = cs_n ? 5'h00 : rise_cnt_r + 5'(sclk_rise);
  assign rise_age_nxt = sclk_rise ? 0 : (rise_age_r < 1000 ? rise_age_r + 1 : rise_age_r);
  assign sync_age_nxt = sin_rise ? 0 : (sync_age_r < 5000 ? sync_age_r + 1 : sync_age_r);

  // Edge history; after reset no sync is pending, so ages start saturated
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sclk_q_r <= 1'b0;
      sin_q_r <= 1'b0;
      rise_cnt_r <= 5'h00;
      rise_age_r <= 1000;
      sync_age_r <= 5000;
    end else begin
      sclk_q_r <= sclk;
      sin_q_r <= sync_in;
      rise_cnt_r <= rise_cnt_nxt;
      rise_age_r <= rise_age_nxt;
      sync_age_r <= sync_age_nxt;
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  // Frame shapes
  sequence sclk_high_s;
    sclk [*8] ##1 !sclk;
  endsequence
  sequence sync_pulse_s;
    sync_out [*4] ##1 !sync_out;
  endsequence
  sequence lead_low_s;
    !sclk [*8];
  endsequence

  sync_width_a: assert property ($rose(sync_out) |-> sync_pulse_s)
    else $error("sync pulse width wrong");
  sync_moment_a: assert property ($rose(sync_out) |->
    !cs_n && rise_cnt_r == 5'h10 && rise_age_r <= 8)
    else $error("sync not tied to the last serial rise");
  sync_loop_a: assert property (sync_in == sync_out)
    else $error("sync loopback broken");
  settle_gap_a: assert property (data_ready_pin |-> sync_age_r >= 2000)
    else $error("data released before settling");
  ready_pulse_a: assert property (data_ready_pin |=> !data_ready_pin)
    else $error("data ready longer than one cycle");
  half_period_a: assert property ($rose(sclk) |-> sclk_high_s)
    else $error("serial clock high phase wrong");
  select_lead_a: assert property ($fell(cs_n) |-> lead_low_s)
    else $error("serial clock too soon after select");
  clock_idle_a: assert property (cs_n |-> !sclk)
    else $error("serial clock outside frame");
  mosi_hold_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("host data moved while clock high");
  frame_gap_a: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("frames too close");

  cover property ($rose(sync_out));
endmodule

// [tb/tb_sync_softreset_oneshot_ctrl.sv]
// Testbench: host and converter ends joined, driven over Wishbone
`timescale 1ns/100ps
module tb_sync_softreset_oneshot_ctrl
  import ssoc_pkg::*;
;
  logic core_clk, rstn, ce, wb_cyc, wb_stb, wb_we, wb_ack, sclk_q, sync_q;
  logic [3:0] wb_adr, wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r;
  logic [7:0] data_control;
  logic filter_reset, settling, conv_strobe, core_reset;
  logic [15:0] mosi_sr;
  int error_cnt, n_compared, n_sync, n_frst, n_conv, n_crst, n_cstb;

  ssoc_link_if lnk();
  ssoc_dev ssoc_dev_i (.CORE_CLK(core_clk), .RSTN(rstn), .CE(ce), .LNK(lnk),
    .DATA_CONTROL(data_control), .FILTER_RESET(filter_reset), .SETTLING(settling),
    .CONV_STROBE(conv_strobe), .CORE_RESET(core_reset));
  ssoc_host ssoc_host_i (.CORE_CLK(core_clk), .RSTN(rstn), .CE(ce), .WB_CYC_I(wb_cyc),
    .WB_STB_I(wb_stb), .WB_WE_I(wb_we), .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel),
    .WB_DAT_I(wb_dat_w), .WB_DAT_O(wb_dat_r), .WB_ACK_O(wb_ack), .LNK(lnk));
  ssoc_asserts ssoc_asserts_i (.CORE_CLK(core_clk), .RSTN(rstn), .sclk(lnk.sclk),
    .cs_n(lnk.cs_n), .mosi(lnk.mosi), .miso(lnk.miso), .sync_out(lnk.sync_out),
    .sync_in(lnk.sync_in), .data_ready_pin(lnk.data_ready_pin));

  // Master clock
  always #(CLK_NS / 2) core_clk = ~core_clk;

  // Wire monitor: host bits as sent, and event counts of the converter end
  always @(posedge core_clk) begin
    sclk_q <= lnk.sclk;
    sync_q <= lnk.sync_out;
    if (!lnk.cs_n && lnk.sclk && !sclk_q) mosi_sr <= {mosi_sr[14:0], lnk.mosi};
    if (lnk.sync_out && !sync_q) n_sync++;
    if (filter_reset === 1'b1) n_frst++;
    if (lnk.data_ready_pin === 1'b1) n_conv++;
    if (core_reset === 1'b1) n_crst++;
    if (conv_strobe === 1'b1) n_cstb++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic single cycle; waits up to 50 cycles for ack, then counts a mismatch
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd,
                    output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat_w <= wd;
    @(posedge core_clk);
    while (wb_ack !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 50) chk(32'h0, 32'h1);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  // One serial command; returns the answer that came back during it
  task automatic frame(input logic [15:0] cmd, output logic [15:0] ans);
    logic [31:0] r;
    int n;
    n = 0;
    wb(1'b1, WB_CMD_OFS, 32'(cmd), r);
    r = 32'h1;
    while (r[ST_BUSY] !== 1'b0 && n < 300) begin
      wb(1'b0, WB_STAT_OFS, 32'h0, r);
      n++;
    end
    // A frame that never ends counts as a mismatch
    if (n == 300) chk(32'h0, 32'h1);
    // The status read that shows idle also shows the fresh answer
    chk(32'(r[ST_RESP_NEW]), 32'h1);
    chk(32'(mosi_sr), 32'(cmd));
    wb(1'b0, WB_RESP_OFS, 32'h0, r);
    ans = r[15:0];
  endtask

  task automatic dcw(input logic [7:0] d);
    logic [15:0] a;
    frame({1'b0, DC_ADDR, d}, a);
  endtask

  // Single exit for both the tests and the watchdog
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog: all tests need roughly a quarter of this span
  initial begin
    #500000;
    error_cnt++;
    complete_run();
  end

  initial begin
    logic [31:0] r;
    logic [15:0] a;
    logic [7:0] s0;
    logic [7:0] sq [6];
    int c0, k;
    {core_clk, rstn, wb_cyc, wb_stb, wb_we, sclk_q, sync_q} = 7'h00;
    ce = 1'b1;
    wb_adr = 4'h0;
    wb_sel = 4'hF;
    wb_dat_w = 32'h0;
    mosi_sr = 16'h0000;
    {error_cnt, n_compared, n_sync, n_frst, n_conv, n_crst, n_cstb} = '0;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    chk(32'(data_control), 32'h80);
    wb(1'b0, 4'hC, 32'hFFFFFFFF, r);
    chk(r, 32'h0);
    frame({RW_READ, DC_ADDR, 8'h00}, a);
    // Command register reads back the word last sent
    wb(1'b0, WB_CMD_OFS, 32'h0, r);
    chk(r, 32'h0000_8600);
    frame({RW_READ, DC_ADDR, 8'h00}, a);
    chk(32'(a), 32'h0680);
    // Software sync: low alone does nothing, low to high fires once
    wb(1'b0, WB_STAT_OFS, 32'h0, r);
    s0 = r[ST_SYNC_MSB:ST_SYNC_LSB];
    k = n_sync;
    c0 = n_frst;
    dcw(8'h00);
    chk(32'(data_control), 32'h00);
    chk(32'(n_sync - k), 32'h0);
    dcw(8'h80);
    chk(32'(n_sync - k), 32'h1);
    chk(32'(n_frst - c0), 32'h1);
    chk(32'(settling), 32'h1);
    dcw(8'h80);
    chk(32'(n_sync - k), 32'h1);
    // Two successive pulses, as a chained group needs
    dcw(8'h00);
    dcw(8'h80);
    wb(1'b0, WB_STAT_OFS, 32'h0, r);
    chk(32'(8'(r[ST_SYNC_MSB:ST_SYNC_LSB] - s0)), 32'h2);
    chk(32'(n_frst - c0), 32'h2);
    c0 = n_conv;
    repeat (1700) @(posedge core_clk);
    chk(32'(n_conv - c0), 32'h0);
    repeat (1300) @(posedge core_clk);
    chk(32'(n_conv > c0), 32'h1);
    // One-shot: a single result per sync edge
    dcw(8'h10);
    dcw(8'h90);
    chk(32'(data_control), 32'h90);
    c0 = n_conv;
    k = n_cstb;
    repeat (3000) @(posedge core_clk);
    chk(32'(n_conv - c0), 32'h1);
    chk(32'(n_cstb - k), 32'h1);
    // Soft reset in two steps, then the marker answer
    k = n_crst;
    dcw(8'h93);
    dcw(8'h92);
    chk(32'(data_control), 32'h80);
    chk(32'(n_crst - k), 32'h1);
    frame({RW_READ, DC_ADDR, 8'h00}, a);
    frame({RW_READ, DC_ADDR, 8'h00}, a);
    chk(32'(a), 32'h0E00);
    frame({RW_READ, DC_ADDR, 8'h00}, a);
    chk(32'(a), 32'h0680);
    // Broken sequences: armed step dropped, no-effect codes between steps
    sq = '{8'h13, 8'h11, 8'h12, 8'h03, 8'h00, 8'h02};
    for (int i = 0; i < 6; i++) begin
      dcw(sq[i]);
      if (i % 3 == 2) begin
        chk(32'(data_control), 32'(sq[i]));
        chk(32'(n_crst - k), 32'h1);
      end
    end
    complete_run();
  end
endmodule
